// file: hw/acrc_clock_rate_config.sv
// Primary clock rate configuration: register at the control port,
// rate selection, detection against standard rates, auto/custom mode.
// Assumes a byte-wide synchronous control port and synchronous frame sync.
`timescale 1ns/100ps
// How it works
// - rate bits 7:2, tolerance bit 1, custom bit 0
// - selector zero means rate is detected
// - codes 1..40 fix a nominal rate
// - fixed code accepts rate inside its band
// - tolerance bit picks 1% or 5% detection
// - custom bit hands dividers to software
module acrc_clock_rate_config #(
  parameter int GATE_CYCLES = acrc_pkg::ACRC_GATE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic frame_sync,
  output logic [19:0] primary_rate_hz,
  output logic primary_rate_locked,
  output logic primary_rate_auto,
  output logic custom_clock_en,
  output logic rate_code_reserved
);
  import acrc_pkg::*;

  // ==========================================================
  // Control register and its read port
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [5:0] primary_rate_selector;
  logic primary_rate_tolerance_sel;
  logic custom_sel;

  assign primary_rate_selector = cfg_reg[ACRC_RATE_MSB:ACRC_RATE_LSB];
  assign primary_rate_tolerance_sel = cfg_reg[ACRC_TOL_BIT];
  assign custom_sel = cfg_reg[ACRC_CUSTOM_BIT];

  always_comb begin
    cfg_next = cfg_reg;
    rdata_next = rdata_reg;
    if (reg_wr && reg_addr == ACRC_PRIMARY_CLOCK_RATE_SELECT_ADDR) begin
      cfg_next = reg_wdata;
    end
    // Reads see the register as it stood before a write in that cycle
    if (reg_rd) begin
      case (reg_addr)
        ACRC_PRIMARY_CLOCK_RATE_SELECT_ADDR: rdata_next = cfg_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cfg_reg <= ACRC_PRIMARY_RESET;
      rdata_reg <= 8'h00;
    end else begin
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Rate measurement
  logic [19:0] meas_hz;
  logic meas_valid;

  // Edges are counted per gate window; the window length sets the scale
  acrc_rate_meter #(.GATE_CYCLES(GATE_CYCLES)) u_meter (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .frame_sync(frame_sync),
    .rate_hz(meas_hz),
    .rate_valid(meas_valid)
  );

  // ==========================================================
  // Rate decision
  acrc_mode_t mode;
  logic [19:0] rate_reg;
  logic [19:0] rate_next;
  logic lock_reg;
  logic lock_next;
  logic auto_reg;
  logic auto_next;
  logic cust_reg;
  logic cust_next;
  logic resv_reg;
  logic resv_next;
  logic [39:0] band;
  logic [19:0] band_low;
  logic [19:0] band_high;
  logic in_band;
  logic [19:0] auto_hit;
  logic auto_found;
  logic [19:0] tol_pct;
  logic [ACRC_RATE_LAST:1] code_hit;

  // ==========================================================
  // Mode select
  // Selector zero detects, 1..40 fix a rate, anything above is reserved
  always_comb begin
    if (primary_rate_selector == ACRC_RATE_AUTO) begin
      mode = ACRC_ST_AUTO;
    end else if (primary_rate_selector <= ACRC_RATE_LAST) begin
      mode = ACRC_ST_FIXED;
    end else begin
      mode = ACRC_ST_RESERVED;
    end
    band = acrc_band(primary_rate_selector);
    tol_pct = primary_rate_tolerance_sel ? ACRC_TOL_LOOSE_PCT :
              ACRC_TOL_TIGHT_PCT;
  end

  // A fixed code only locks once a window has been measured
  assign band_low = band[39:20];
  assign band_high = band[19:0];
  assign in_band = meas_valid && meas_hz >= band_low &&
                   meas_hz <= band_high;

  // ==========================================================
  // Standard rate match
  // One comparator per standard rate; the product is formed at 27 bits
  // so that the top rate times the loose tolerance cannot wrap.
  for (genvar g = 1; g <= ACRC_RATE_LAST; g++) begin : g_match
    logic [19:0] nom;
    logic [26:0] diff;
    logic [26:0] lim;
    assign nom = acrc_nominal(6'(g));
    assign diff = (meas_hz > nom) ? 27'(meas_hz - nom) :
                  27'(nom - meas_hz);
    assign lim = 27'(nom) * 27'(tol_pct);
    assign code_hit[g] = 27'(diff * 27'd100) <= lim;
  end

  // Lowest code last, so the highest matching standard rate wins
  always_comb begin
    auto_hit = 20'h0;
    auto_found = 1'b0;
    for (int c = int'(ACRC_RATE_LAST); c >= 1; c--) begin
      if (code_hit[c]) begin
        auto_hit = acrc_nominal(6'(c));
        auto_found = 1'b1;
      end
    end
  end

  always_comb begin
    rate_next = rate_reg;
    lock_next = lock_reg;
    case (mode)
      ACRC_ST_AUTO: begin
        // Held until the first window; after it meas_valid stays set and the decision is re-made each cycle from the last count
        if (meas_valid) begin
          rate_next = auto_found ? auto_hit : 20'h0;
          lock_next = auto_found;
        end
      end
      ACRC_ST_FIXED: begin
        rate_next = acrc_nominal(primary_rate_selector);
        lock_next = in_band;
      end
      ACRC_ST_RESERVED: begin
        // Stored as written, but no rate is reported
        rate_next = 20'h0;
        lock_next = 1'b0;
      end
      default: begin
        rate_next = 20'h0;
        lock_next = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Rate and lock registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rate_reg <= 20'h0;
      lock_reg <= 1'b0;
    end else begin
      rate_reg <= rate_next;
      lock_reg <= lock_next;
    end
  end

  // ==========================================================
  // Mode flags
  // Flags follow the stored selector and custom bit, one cycle after the register
  always_comb begin
    auto_next = (mode == ACRC_ST_AUTO);
    cust_next = custom_sel;
    resv_next = (mode == ACRC_ST_RESERVED);
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      auto_reg <= 1'b1;
      cust_reg <= 1'b0;
      resv_reg <= 1'b0;
    end else begin
      auto_reg <= auto_next;
      cust_reg <= cust_next;
      resv_reg <= resv_next;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = rdata_reg;
  assign primary_rate_hz = rate_reg;
  assign primary_rate_locked = lock_reg;
  assign primary_rate_auto = auto_reg;
  assign custom_clock_en = cust_reg;
  assign rate_code_reserved = resv_reg;
endmodule

// file: hw/acrc_pkg.sv
// Package: register map, field layout, reset values and rate tables
// for the primary clock rate configuration block.
// Assumes a single 10 MHz system clock and a byte-wide control port.
package acrc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ACRC_PRIMARY_CLOCK_RATE_SELECT_ADDR = 8'h32;
  localparam logic [7:0] ACRC_SECONDARY_CLOCK_RATE_SELECT_ADDR = 8'h33;
  localparam logic [7:0] ACRC_PRIMARY_RESET = 8'h00;
  localparam logic [7:0] ACRC_SECONDARY_RESET = 8'h00;
  // ==========================================================
  // Field layout
  localparam int ACRC_RATE_MSB = 7;
  localparam int ACRC_RATE_LSB = 2;
  localparam int ACRC_TOL_BIT = 1;
  localparam int ACRC_CUSTOM_BIT = 0;
  localparam logic [5:0] ACRC_RATE_AUTO = 6'h00;
  localparam logic [5:0] ACRC_RATE_LAST = 6'h28;
  // ==========================================================
  // Timing: the measurement gate is one second of the system clock
  localparam int ACRC_CLK_HZ = 10000000;
  localparam int ACRC_GATE_MS = 1000;
  localparam int ACRC_GATE_CYCLES = ACRC_CLK_HZ / 1000 * ACRC_GATE_MS;
  // Tolerance in percent for automatic detection
  localparam logic [19:0] ACRC_TOL_TIGHT_PCT = 20'h00001;
  localparam logic [19:0] ACRC_TOL_LOOSE_PCT = 20'h00005;

  typedef enum logic [1:0] {
    ACRC_ST_AUTO,
    ACRC_ST_FIXED,
    ACRC_ST_RESERVED
  } acrc_mode_t;

  // Nominal rate for codes 1..40, index = code
  function automatic logic [19:0] acrc_nominal(input logic [5:0] code);
    case (code)
      6'h01: acrc_nominal = 20'd768000;
      6'h02: acrc_nominal = 20'd614400;
      6'h03: acrc_nominal = 20'd512000;
      6'h04: acrc_nominal = 20'd438857;
      6'h05: acrc_nominal = 20'd384000;
      6'h06: acrc_nominal = 20'd341333;
      6'h07: acrc_nominal = 20'd307200;
      6'h08: acrc_nominal = 20'd256000;
      6'h09: acrc_nominal = 20'd219429;
      6'h0a: acrc_nominal = 20'd192000;
      6'h0b: acrc_nominal = 20'd170667;
      6'h0c: acrc_nominal = 20'd153600;
      6'h0d: acrc_nominal = 20'd128000;
      6'h0e: acrc_nominal = 20'd109714;
      6'h0f: acrc_nominal = 20'd96000;
      6'h10: acrc_nominal = 20'd85333;
      6'h11: acrc_nominal = 20'd76800;
      6'h12: acrc_nominal = 20'd64000;
      6'h13: acrc_nominal = 20'd54857;
      6'h14: acrc_nominal = 20'd48000;
      6'h15: acrc_nominal = 20'd42667;
      6'h16: acrc_nominal = 20'd38400;
      6'h17: acrc_nominal = 20'd32000;
      6'h18: acrc_nominal = 20'd27429;
      6'h19: acrc_nominal = 20'd24000;
      6'h1a: acrc_nominal = 20'd21333;
      6'h1b: acrc_nominal = 20'd19200;
      6'h1c: acrc_nominal = 20'd16000;
      6'h1d: acrc_nominal = 20'd13714;
      6'h1e: acrc_nominal = 20'd12000;
      6'h1f: acrc_nominal = 20'd10667;
      6'h20: acrc_nominal = 20'd9600;
      6'h21: acrc_nominal = 20'd8000;
      6'h22: acrc_nominal = 20'd6857;
      6'h23: acrc_nominal = 20'd6000;
      6'h24: acrc_nominal = 20'd5333;
      6'h25: acrc_nominal = 20'd4800;
      6'h26: acrc_nominal = 20'd4000;
      6'h27: acrc_nominal = 20'd3429;
      6'h28: acrc_nominal = 20'd3000;
      default: acrc_nominal = 20'd0;
    endcase
  endfunction

  // Accepted band {low, high} for codes 1..40
  function automatic logic [39:0] acrc_band(input logic [5:0] code);
    case (code)
      6'h01: acrc_band = {20'd670320, 20'd791040};
      6'h02: acrc_band = {20'd536256, 20'd632832};
      6'h03: acrc_band = {20'd446880, 20'd527360};
      6'h04: acrc_band = {20'd383040, 20'd452022};
      6'h05: acrc_band = {20'd335160, 20'd395520};
      6'h06: acrc_band = {20'd297920, 20'd351573};
      6'h07: acrc_band = {20'd268128, 20'd316416};
      6'h08: acrc_band = {20'd223440, 20'd263680};
      6'h09: acrc_band = {20'd191520, 20'd226011};
      6'h0a: acrc_band = {20'd167580, 20'd197760};
      6'h0b: acrc_band = {20'd148960, 20'd175786};
      6'h0c: acrc_band = {20'd134064, 20'd158208};
      6'h0d: acrc_band = {20'd111720, 20'd131840};
      6'h0e: acrc_band = {20'd95760, 20'd113005};
      6'h0f: acrc_band = {20'd83790, 20'd98880};
      6'h10: acrc_band = {20'd74480, 20'd87893};
      6'h11: acrc_band = {20'd67032, 20'd79104};
      6'h12: acrc_band = {20'd55860, 20'd65920};
      6'h13: acrc_band = {20'd47880, 20'd56502};
      6'h14: acrc_band = {20'd41895, 20'd49440};
      6'h15: acrc_band = {20'd37240, 20'd43946};
      6'h16: acrc_band = {20'd33516, 20'd39552};
      6'h17: acrc_band = {20'd27930, 20'd32960};
      6'h18: acrc_band = {20'd23940, 20'd28251};
      6'h19: acrc_band = {20'd20947, 20'd24720};
      6'h1a: acrc_band = {20'd18620, 20'd21973};
      6'h1b: acrc_band = {20'd16758, 20'd19776};
      6'h1c: acrc_band = {20'd13965, 20'd16480};
      6'h1d: acrc_band = {20'd11970, 20'd14125};
      6'h1e: acrc_band = {20'd10473, 20'd12360};
      6'h1f: acrc_band = {20'd9310, 20'd10986};
      6'h20: acrc_band = {20'd8379, 20'd9888};
      6'h21: acrc_band = {20'd6982, 20'd8240};
      6'h22: acrc_band = {20'd5985, 20'd7062};
      6'h23: acrc_band = {20'd5336, 20'd6180};
      6'h24: acrc_band = {20'd4655, 20'd5493};
      6'h25: acrc_band = {20'd4189, 20'd4944};
      6'h26: acrc_band = {20'd3491, 20'd4120};
      6'h27: acrc_band = {20'd2992, 20'd3531};
      6'h28: acrc_band = {20'd2618, 20'd3090};
      default: acrc_band = 40'h0;
    endcase
  endfunction
endpackage

// file: hw/acrc_rate_meter.sv
// Rate meter: counts frame-sync rising edges over a gate window.
// Assumes frame sync is synchronous to sys_clk.
`timescale 1ns/100ps
module acrc_rate_meter #(
  parameter int GATE_CYCLES = acrc_pkg::ACRC_GATE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic frame_sync,
  output logic [19:0] rate_hz,
  output logic rate_valid
);
  import acrc_pkg::*;
  logic [31:0] gate_reg, gate_next;
  logic [19:0] count_reg, count_next, rate_reg, rate_next;
  logic fs_reg, valid_reg, valid_next;

  always_comb begin
    gate_next = gate_reg + 32'h1;
    count_next = count_reg;
    rate_next = rate_reg;
    valid_next = valid_reg;
    if (frame_sync && !fs_reg && count_reg != 20'hfffff) begin
      count_next = count_reg + 20'h1;
    end
    if (gate_reg == 32'(GATE_CYCLES - 1)) begin
      gate_next = 32'h0;
      rate_next = count_next;
      valid_next = 1'b1;
      count_next = 20'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      gate_reg <= 32'h0;
      count_reg <= 20'h0;
      rate_reg <= 20'h0;
      valid_reg <= 1'b0;
      fs_reg <= 1'b0;
    end else begin
      gate_reg <= gate_next;
      count_reg <= count_next;
      rate_reg <= rate_next;
      valid_reg <= valid_next;
      fs_reg <= frame_sync;
    end
  end

  assign rate_hz = rate_reg;
  assign rate_valid = valid_reg;
endmodule

// file: test/acrc_clock_rate_config_props.sv
// Checker: port-level assertions for the clock rate configuration block.
// Assumes it is bound onto the top module; one clock domain.
`timescale 1ns/100ps
module acrc_clock_rate_config_props #(
  parameter int GATE_CYCLES = acrc_pkg::ACRC_GATE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic frame_sync,
  input wire logic [19:0] primary_rate_hz,
  input wire logic primary_rate_locked,
  input wire logic primary_rate_auto,
  input wire logic custom_clock_en,
  input wire logic rate_code_reserved
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic wr_cfg;
  assign wr_cfg = reg_wr && reg_addr == 8'h32;
  a_cfg_readback: assert property (
    wr_cfg ##1 (reg_rd && !reg_wr && reg_addr == 8'h32)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback wrong");
  a_unmapped_read: assert property (
    reg_rd && reg_addr != 8'h32 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_custom_follow: assert property (
    wr_cfg |-> ##2 custom_clock_en == $past(reg_wdata[0], 2))
    else $error("custom enable wrong");
  a_auto_flag: assert property (
    wr_cfg |-> ##2 primary_rate_auto == ($past(reg_wdata[7:2], 2) == 6'h00))
    else $error("auto flag wrong");
  a_reserved_flag: assert property (
    wr_cfg |-> ##2 rate_code_reserved == ($past(reg_wdata[7:2], 2) > 6'h28))
    else $error("reserved flag wrong");
  a_fixed_rate48: assert property (
    wr_cfg && reg_wdata[7:2] == 6'h14 |-> ##2 primary_rate_hz == 20'd48000)
    else $error("code 20 rate wrong");
  a_reserved_rate: assert property (
    wr_cfg && reg_wdata[7:2] > 6'h28 |-> ##2 primary_rate_hz == 20'h0)
    else $error("reserved code gave a rate");
  a_lock_sane: assert property (
    primary_rate_locked |-> !rate_code_reserved && primary_rate_hz != 20'h0)
    else $error("lock without a rate");
endmodule

// file: test/acrc_frame_source.sv
// Partner: frame sync source standing in for the host serial port.
// Assumes frame sync is sampled on sys_clk; idles low while stopped.
`timescale 1ns/100ps
module acrc_frame_source #(
  parameter int PERIOD = 3
) (
  input wire logic sys_clk,
  input wire logic run,
  output logic frame_sync = 1'b0
);
  int cnt = 0;
  always @(posedge sys_clk) begin
    cnt <= (cnt + 1) % PERIOD;
    frame_sync <= run && cnt == 0;
  end
endmodule

// file: test/asi_clock_rate_config_tb.sv
// Testbench: register access, rate decode and lock of the rate block.
// Assumes the frame source partner and the bound checker.
`timescale 1ns/100ps
bind acrc_clock_rate_config acrc_clock_rate_config_props #(
  .GATE_CYCLES(GATE_CYCLES)) i_props (
  .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .frame_sync(frame_sync),
  .primary_rate_hz(primary_rate_hz),
  .primary_rate_locked(primary_rate_locked),
  .primary_rate_auto(primary_rate_auto),
  .custom_clock_en(custom_clock_en),
  .rate_code_reserved(rate_code_reserved));
module asi_clock_rate_config_tb;
  localparam int GATE = 8700;
  localparam int TWIN = 2 * GATE + 20;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run = 1'b0;
  logic [7:0] reg_rdata;
  logic frame_sync;
  logic [19:0] primary_rate_hz;
  logic primary_rate_locked;
  logic primary_rate_auto;
  logic custom_clock_en;
  logic rate_code_reserved;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  acrc_clock_rate_config #(.GATE_CYCLES(GATE)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_sync(frame_sync),
    .primary_rate_hz(primary_rate_hz),
    .primary_rate_locked(primary_rate_locked),
    .primary_rate_auto(primary_rate_auto),
    .custom_clock_en(custom_clock_en),
    .rate_code_reserved(rate_code_reserved));
  acrc_frame_source #(.PERIOD(3)) i_src (
    .sys_clk(sys_clk), .run(run), .frame_sync(frame_sync));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input string name, input logic [19:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic t_reset;
    logic [7:0] d;
    rd(8'h32, d);
    chk("cfg", 20'(d), 20'h0);
    chk("auto", 20'(primary_rate_auto), 20'h1);
    chk("custom", 20'(custom_clock_en), 20'h0);
    chk("locked", 20'(primary_rate_locked), 20'h0);
    $display("t_reset done");
  endtask
  task automatic t_fields;
    logic [7:0] d;
    logic [7:0] wd [6] = '{8'h04, 8'h50, 8'ha1, 8'ha4, 8'hfe, 8'h02};
    logic [19:0] hz [6] = '{20'd768000, 20'd48000, 20'd3000, 0, 0, 0};
    for (int i = 0; i < 6; i++) begin
      wr(8'h32, wd[i]);
      rd(8'h32, d);
      chk("cfg", 20'(d), 20'(wd[i]));
      chk("rate", primary_rate_hz, hz[i]);
      chk("auto", 20'(primary_rate_auto), 20'(wd[i][7:2] == 0));
      chk("custom", 20'(custom_clock_en), 20'(wd[i][0]));
      chk("rsv", 20'(rate_code_reserved), 20'(wd[i][7:2] > 40));
    end
    wr(8'h33, 8'hff);
    rd(8'h33, d);
    chk("unmapped", 20'(d), 20'h0);
    step(1);
    rd(8'h32, d);
    chk("cfg kept", 20'(d), 20'h02);
    $display("t_fields done");
  endtask
  task automatic measure(input logic [7:0] d, input logic on,
                         input logic [19:0] hz, input logic lk);
    run = 1'b0;
    step(1);
    wr(8'h32, d);
    run = on;
    step(TWIN);
    chk("rate", primary_rate_hz, hz);
    chk("locked", 20'(primary_rate_locked), 20'(lk));
  endtask
  task automatic t_lock;
    measure(8'ha0, 1'b1, 20'd3000, 1'b1);
    measure(8'h02, 1'b1, 20'd3000, 1'b1);
    measure(8'h00, 1'b1, 20'h0, 1'b0);
    measure(8'ha0, 1'b0, 20'd3000, 1'b0);
    $display("t_lock done");
  endtask
  initial begin
    step(2);
    rstn = 1'b1;
    t_reset();
    t_fields();
    t_lock();
    results();
  end
endmodule
